// ### hdl/nvsp_regs.svh
`ifndef NVSP_REGS_SVH
`define NVSP_REGS_SVH

// ==========================================
// Clock and timing
`define NVSP_CLK_PERIOD_NS 10
`define NVSP_STORE_TIME_NS 8000
`define NVSP_RECALL_TIME_NS 2000
`define NVSP_HIGH_DRIVE_TIME_NS 50
`define NVSP_STORE_CYCLES (`NVSP_STORE_TIME_NS / `NVSP_CLK_PERIOD_NS)
`define NVSP_RECALL_CYCLES (`NVSP_RECALL_TIME_NS / `NVSP_CLK_PERIOD_NS)
`define NVSP_HIGH_CYCLES \
    ((`NVSP_HIGH_DRIVE_TIME_NS + `NVSP_CLK_PERIOD_NS - 1) / `NVSP_CLK_PERIOD_NS)

// ==========================================
// Array geometry
`define NVSP_MEM_WORDS 131072

// ==========================================
// Instruction codes
`define NVSP_OP_WRSR 8'h01
`define NVSP_OP_WRITE 8'h02
`define NVSP_OP_READ 8'h03
`define NVSP_OP_WR_DISABLE 8'h04
`define NVSP_OP_RDSR 8'h05
`define NVSP_OP_WREN 8'h06
`define NVSP_OP_STORE 8'h30
`define NVSP_OP_RECALL 8'h31
`define NVSP_OP_ASEN 8'h32
`define NVSP_OP_ASDIS 8'h33

// ==========================================
// Status byte fields and reset values
`define NVSP_SR_BUSY 0
`define NVSP_SR_WEL 1
`define NVSP_SR_BP_LO 2
`define NVSP_SR_BP_HI 3
`define NVSP_SR_WPEN 7
`define NVSP_BP_RESET 2'h0
`define NVSP_AUTO_EN_RESET 1'b1

`endif

// ### hdl/nvsp_pkg.sv
package nvsp_pkg;

    // ==========================================
    // Serial sequence states
    typedef enum logic [2:0] {
        ST_CMD = 3'h0,
        ST_RADDR = 3'h1,
        ST_WADDR = 3'h2,
        ST_READ = 3'h3,
        ST_WRITE = 3'h4,
        ST_RDSR = 3'h5,
        ST_WRSR = 3'h6,
        ST_IGNORE = 3'h7
    } nvsp_spi_state_type;

    // ==========================================
    // Store and recall states
    typedef enum logic [1:0] {
        NV_IDLE = 2'h0,
        NV_STORE = 2'h1,
        NV_RECALL = 2'h2,
        NV_HIGH = 2'h3
    } nvsp_nv_state_type;

endpackage : nvsp_pkg

// ### hdl/nvsp_sync.sv
`timescale 1ns/100ps

module nvsp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage is read by the second stage only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule : nvsp_sync

// ### hdl/nvsp_mem.sv
`timescale 1ns/100ps
`include "nvsp_regs.svh"

module nvsp_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [16:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] mem_q [0:`NVSP_MEM_WORDS-1];
    logic [7:0] rdata_q;

    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[addr] <= wdata;
        end
        rdata_q <= mem_q[addr];
    end

    assign rdata = rdata_q;

endmodule : nvsp_mem

// ### hdl/nvsp_slave_port.sv
`timescale 1ns/100ps
`include "nvsp_regs.svh"

// Summary of operation
// - Serial traffic is honoured only while chip select is low.
// - Chip select high ends the transfer and signals standby.
// - Serial input bits are taken on the rising serial clock edge.
// - Serial output changes on the falling serial clock edge.
// - Master uses mode 0 or mode 3; both idle levels work.
// - Suspend input freezes the transfer and keeps the sequence state.
// - During store or recall the busy pin is low and busy is set.
// - After a store the busy pin is driven high briefly, then released.
// - An external low on the busy pin requests a hardware store.
// - Memory reads and writes are blocked during store or recall.
// - Reads and writes run at full serial rate with no wait cycles.
// - The array holds 131072 bytes of eight bits.
// - Two block-protect bits guard a quarter, half or whole array.
// - Write-protect input locks status writes when WPEN is set; write disable instruction protects writes.
// - Store, recall, auto-save disable and enable instructions are decoded.
// - A store copies the whole array to nonvolatile cells at once.
// - Conventional read and write instruction codes are accepted.
// - Auto and pin stores run only after a write; software always.
// - A write is opcode, three address bytes, then data bytes.
// - Burst address advances each byte and wraps to zero.
module nvsp_slave_port (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    input wire logic hold_n,
    input wire logic power_fail,
    input wire logic store_busy_pin_i,
    output logic so,
    output logic so_oe,
    output logic store_busy_pin_o,
    output logic store_busy_pin_oe,
    output logic standby,
    output logic busy,
    output logic nv_store_start,
    output logic nv_recall_start
);

    // ==========================================
    // Pin synchronisers
    logic [6:0] pins_raw;
    logic [6:0] pins_s;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic wp_n_s;
    logic hold_n_s;
    logic pf_s;
    logic pin_s;

    assign pins_raw = {store_busy_pin_i, power_fail, hold_n, wp_n, si, sck, cs_n};

    nvsp_sync #(
        .WIDTH(7),
        .RESET_VAL(7'h59)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign cs_n_s = pins_s[0];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[2];
    assign wp_n_s = pins_s[3];
    assign hold_n_s = pins_s[4];
    assign pf_s = pins_s[5];
    assign pin_s = pins_s[6];

    // ==========================================
    // Register declarations
    nvsp_pkg::nvsp_spi_state_type state_q;
    nvsp_pkg::nvsp_spi_state_type state_d;
    nvsp_pkg::nvsp_nv_state_type nv_q;
    nvsp_pkg::nvsp_nv_state_type nv_d;
    logic sck_prev_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_q;
    logic [1:0] byte_cnt_q;
    logic [16:0] addr_q;
    logic [6:0] tx_q;
    logic tx_on_q;
    logic so_q;
    logic so_oe_q;
    logic wel_q;
    logic [1:0] bp_q;
    logic wpen_q;
    logic auto_en_q;
    logic dirty_q;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic busy_q;
    logic pin_o_q;
    logic pin_oe_q;
    logic standby_q;
    logic store_pulse_q;
    logic recall_pulse_q;

    // ==========================================
    // Serial clock edges
    function automatic logic prot(input logic [16:0] a, input logic [1:0] bp);
        return (bp == 2'h3) | ((bp == 2'h2) & a[16]) | ((bp == 2'h1) & (&a[16:15]));
    endfunction : prot

    logic active;
    logic sck_rise;
    logic sck_fall;
    logic byte_done;
    logic [7:0] rx_byte;

    // active low select; suspend gates edges
    assign active = ~cs_n_s & hold_n_s;
    // mode 0 and 3 share edges
    assign sck_rise = active & sck_s & ~sck_prev_q;
    assign sck_fall = active & ~sck_s & sck_prev_q;
    assign rx_byte = {rx_q, si_s};
    assign byte_done = sck_rise & (bit_cnt_q == 3'h7);

    // ==========================================
    // Instruction decode
    logic cmd_done;
    logic wren_cmd;
    logic wr_disable_cmd;
    logic sw_store;
    logic sw_recall;
    logic asen_cmd;
    logic asdis_cmd;
    logic in_addr;
    logic in_data;
    logic tx_state;
    nvsp_pkg::nvsp_spi_state_type cmd_next;

    assign cmd_done = byte_done & (state_q == nvsp_pkg::ST_CMD);
    assign wren_cmd = cmd_done & (rx_byte == `NVSP_OP_WREN);
    assign wr_disable_cmd = cmd_done & (rx_byte == `NVSP_OP_WR_DISABLE);
    assign sw_store = cmd_done & (rx_byte == `NVSP_OP_STORE);
    assign sw_recall = cmd_done & (rx_byte == `NVSP_OP_RECALL);
    assign asen_cmd = cmd_done & (rx_byte == `NVSP_OP_ASEN);
    assign asdis_cmd = cmd_done & (rx_byte == `NVSP_OP_ASDIS);

    // conventional codes; memory opcodes refused while busy
    assign cmd_next = (rx_byte == `NVSP_OP_READ && !busy_q) ? nvsp_pkg::ST_RADDR :
                      (rx_byte == `NVSP_OP_WRITE && !busy_q) ? nvsp_pkg::ST_WADDR :
                      (rx_byte == `NVSP_OP_RDSR) ? nvsp_pkg::ST_RDSR :
                      (rx_byte == `NVSP_OP_WRSR) ? nvsp_pkg::ST_WRSR :
                      nvsp_pkg::ST_IGNORE;

    assign in_addr = (state_q == nvsp_pkg::ST_RADDR) | (state_q == nvsp_pkg::ST_WADDR);
    assign in_data = (state_q == nvsp_pkg::ST_READ) | (state_q == nvsp_pkg::ST_WRITE);
    assign tx_state = (state_q == nvsp_pkg::ST_READ) | (state_q == nvsp_pkg::ST_RDSR);

    // ==========================================
    // Serial sequence
    always_comb begin
        state_d = state_q;
        if (byte_done) begin
            unique case (state_q)
                nvsp_pkg::ST_CMD: begin
                    state_d = cmd_next;
                end
                nvsp_pkg::ST_RADDR: begin
                    if (byte_cnt_q == 2'h2) begin
                        state_d = nvsp_pkg::ST_READ;
                    end
                end
                nvsp_pkg::ST_WADDR: begin
                    if (byte_cnt_q == 2'h2) begin
                        state_d = nvsp_pkg::ST_WRITE;
                    end
                end
                nvsp_pkg::ST_WRSR: begin
                    state_d = nvsp_pkg::ST_IGNORE;
                end
                nvsp_pkg::ST_READ, nvsp_pkg::ST_WRITE, nvsp_pkg::ST_RDSR,
                nvsp_pkg::ST_IGNORE: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || cs_n_s) begin
            state_q <= nvsp_pkg::ST_CMD;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 2'h0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_q + {2'h0, sck_rise};
            byte_cnt_q <= byte_cnt_q + {1'b0, byte_done & in_addr};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sck_prev_q <= 1'b0;
            standby_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            standby_q <= cs_n_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_q <= 7'h0;
        end else if (sck_rise) begin
            rx_q <= rx_byte[6:0];
        end
    end

    // advance and wrap by natural overflow
    always_ff @(posedge clk) begin
        if (!resetn) begin
            addr_q <= 17'h0;
        end else if (byte_done && in_addr) begin
            addr_q <= {addr_q[8:0], rx_byte};
        end else if (byte_done && in_data) begin
            addr_q <= addr_q + 17'h1;
        end
    end

    // ==========================================
    // Memory and protection
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] status;
    logic [7:0] tx_byte;

    // block protect; no write while busy
    assign mem_we = byte_done & (state_q == nvsp_pkg::ST_WRITE) & wel_q & ~busy_q &
                    ~prot(addr_q, bp_q);

    nvsp_mem u_mem (
        .clk(clk),
        .we(mem_we),
        .addr(addr_q),
        .wdata(rx_byte),
        .rdata(mem_rdata)
    );

    assign status = {wpen_q, 3'h0, bp_q, wel_q, busy_q};
    assign tx_byte = (state_q == nvsp_pkg::ST_RDSR) ? status :
                     (busy_q ? 8'h00 : mem_rdata);

    // ==========================================
    // Serial output
    // output changes on falling edge; next byte already fetched
    always_ff @(posedge clk) begin
        if (!resetn) begin
            so_q <= 1'b0;
            tx_q <= 7'h0;
        end else if (sck_fall && tx_state && bit_cnt_q == 3'h0) begin
            so_q <= tx_byte[7];
            tx_q <= tx_byte[6:0];
        end else if (sck_fall && tx_state) begin
            so_q <= tx_q[6];
            tx_q <= {tx_q[5:0], 1'b0};
        end
    end

    // drive only while shifting read data or status byte
    always_ff @(posedge clk) begin
        if (!resetn || cs_n_s) begin
            tx_on_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            tx_on_q <= tx_on_q | (sck_fall & tx_state);
            so_oe_q <= hold_n_s & (tx_on_q | (sck_fall & tx_state));
        end
    end

    // ==========================================
    // Control and status bits
    logic wrsr_done;
    logic wrsr_ok;

    assign wrsr_done = byte_done & (state_q == nvsp_pkg::ST_WRSR);
    // write-protect pin locks status when enabled
    assign wrsr_ok = wel_q & ~(wpen_q & ~wp_n_s) & ~busy_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wel_q <= 1'b0;
        end else if (wren_cmd) begin
            wel_q <= 1'b1;
        end else if (wr_disable_cmd || wrsr_done) begin
            wel_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bp_q <= `NVSP_BP_RESET;
            wpen_q <= 1'b0;
        end else if (wrsr_done && wrsr_ok) begin
            bp_q <= {rx_byte[`NVSP_SR_BP_HI], rx_byte[`NVSP_SR_BP_LO]};
            wpen_q <= rx_byte[`NVSP_SR_WPEN];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            auto_en_q <= `NVSP_AUTO_EN_RESET;
        end else if (asen_cmd) begin
            auto_en_q <= 1'b1;
        end else if (asdis_cmd) begin
            auto_en_q <= 1'b0;
        end
    end

    // ==========================================
    // Store and recall sequencer
    logic idle;
    logic hw_req;
    logic auto_req;
    logic store_go;
    logic recall_go;

    assign idle = (nv_q == nvsp_pkg::NV_IDLE);
    // external low is a request; own drive masked
    assign hw_req = ~pin_s & ~pin_oe_q;
    assign auto_req = pf_s & auto_en_q;
    // conditional stores need a prior write
    assign store_go = idle & (sw_store | (dirty_q & (hw_req | auto_req)));
    assign recall_go = idle & sw_recall & ~store_go;

    // Write in the start cycle wins, so the byte is stored next time
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dirty_q <= 1'b0;
        end else if (mem_we) begin
            dirty_q <= 1'b1;
        end else if (store_go || recall_go) begin
            dirty_q <= 1'b0;
        end
    end

    always_comb begin
        nv_d = nv_q;
        cnt_d = cnt_q - 12'h1;
        unique case (nv_q)
            nvsp_pkg::NV_IDLE: begin
                cnt_d = 12'h0;
                if (store_go) begin
                    nv_d = nvsp_pkg::NV_STORE;
                    cnt_d = 12'(`NVSP_STORE_CYCLES - 1);
                end else if (recall_go) begin
                    nv_d = nvsp_pkg::NV_RECALL;
                    cnt_d = 12'(`NVSP_RECALL_CYCLES - 1);
                end
            end
            nvsp_pkg::NV_STORE: begin
                if (cnt_q == 12'h0) begin
                    nv_d = nvsp_pkg::NV_HIGH;
                    cnt_d = 12'(`NVSP_HIGH_CYCLES - 1);
                end
            end
            nvsp_pkg::NV_RECALL, nvsp_pkg::NV_HIGH: begin
                if (cnt_q == 12'h0) begin
                    nv_d = nvsp_pkg::NV_IDLE;
                end
            end
        endcase
    end

    // Reset starts the power-up recall
    always_ff @(posedge clk) begin
        if (!resetn) begin
            nv_q <= nvsp_pkg::NV_RECALL;
            cnt_q <= 12'(`NVSP_RECALL_CYCLES - 1);
        end else begin
            nv_q <= nv_d;
            cnt_q <= cnt_d;
        end
    end

    // pin low and busy set together; one start pulse
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_q <= 1'b1;
            pin_oe_q <= 1'b1;
            pin_o_q <= 1'b0;
            store_pulse_q <= 1'b0;
            recall_pulse_q <= 1'b0;
        end else begin
            busy_q <= (nv_d == nvsp_pkg::NV_STORE) | (nv_d == nvsp_pkg::NV_RECALL);
            pin_oe_q <= (nv_d != nvsp_pkg::NV_IDLE);
            pin_o_q <= (nv_d == nvsp_pkg::NV_HIGH);
            store_pulse_q <= store_go;
            recall_pulse_q <= recall_go;
        end
    end

    assign so = so_q;
    assign so_oe = so_oe_q;
    assign store_busy_pin_o = pin_o_q;
    assign store_busy_pin_oe = pin_oe_q;
    assign standby = standby_q;
    assign busy = busy_q;
    assign nv_store_start = store_pulse_q;
    assign nv_recall_start = recall_pulse_q;

    // ==========================================
    // Assertions
    a_select_quiet: assert property (
        @(posedge clk) disable iff (!resetn) cs_n_s |=> !so_oe_q && standby_q
    ) else $error("output driven while deselected");

    a_standby_ends: assert property (
        @(posedge clk) disable iff (!resetn)
        cs_n_s |=> state_q == nvsp_pkg::ST_CMD && bit_cnt_q == 3'h0
    ) else $error("sequence not reset on deselect");

    a_rise_sample: assert property (
        @(posedge clk) disable iff (!resetn) sck_rise |=> rx_q[0] == $past(si_s)
    ) else $error("input bit not taken on rising edge");

    a_fall_shift: assert property (
        @(posedge clk) disable iff (!resetn) $changed(so_q) |-> $past(sck_fall)
    ) else $error("output changed off a falling edge");

    a_hold_freeze: assert property (
        @(posedge clk) disable iff (!resetn)
        (!hold_n_s && !cs_n_s) |=> $stable(bit_cnt_q) && $stable(state_q)
    ) else $error("sequence moved while suspended");

    a_busy_pin_low: assert property (
        @(posedge clk) disable iff (!resetn)
        busy_q |-> store_busy_pin_oe && !store_busy_pin_o
    ) else $error("busy pin not low while busy");

    a_high_drive: assert property (
        @(posedge clk) disable iff (!resetn)
        ($fell(busy_q) && nv_q == nvsp_pkg::NV_HIGH)
        |-> (pin_oe_q && pin_o_q)[*5] ##1 !pin_oe_q
    ) else $error("busy pin high drive length wrong");

    a_pin_request: assert property (
        @(posedge clk) disable iff (!resetn)
        (idle && hw_req && dirty_q) |=> busy_q && nv_q == nvsp_pkg::NV_STORE
    ) else $error("pin request did not start store");

    a_busy_blocks: assert property (
        @(posedge clk) disable iff (!resetn)
        busy_q |-> !mem_we && !(cmd_done && cmd_next == nvsp_pkg::ST_RADDR)
    ) else $error("memory access during store or recall");

    a_protect_hold: assert property (
        @(posedge clk) disable iff (!resetn) mem_we |-> !prot(addr_q, bp_q)
    ) else $error("write into protected block");

    a_clean_skip: assert property (
        @(posedge clk) disable iff (!resetn)
        (idle && !dirty_q && !sw_store && !sw_recall) |=> !busy_q
    ) else $error("store started with no write pending");

    a_addr_wrap: assert property (
        @(posedge clk) disable iff (!resetn)
        (byte_done && in_data && addr_q == 17'h1ffff) |=> addr_q == 17'h0
    ) else $error("burst address did not wrap");

endmodule : nvsp_slave_port

// ### tb/nvsp_master.sv
`timescale 1ns/100ps

module nvsp_master (
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire logic so,
    input wire logic so_oe
);
    logic last_q;
    initial begin
        {cs_n, sck, si, hold_n, last_q} = 5'b10010;
    end
    // ========
    // Byte shift, MSB first
    // 8 MHz link
    task automatic shift(input logic [7:0] tx, input bit hold, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            #62.5;
            if (hold && i == 3) begin
                hold_n = 1'b0;
                #100 sck = 1'b1;
                si = ~si;
                #100 sck = 1'b0;
                si = tx[i];
                #100 hold_n = 1'b1;
                #100;
            end
            sck = 1'b1;
            // Released line shows no stale value
            rx[i] = so_oe ? so : ~last_q;
            if (so_oe) last_q = so;
            #62.5;
        end
    endtask : shift
    task automatic sel(input bit on, input bit cpol);
        sck = cpol;
        if (!on) si = ~si;
        #100 cs_n = ~on;
        #103;
    endtask : sel
endmodule : nvsp_master

// ### tb/spi_nvsram_slave_port_tb_top.sv
`timescale 1ns/100ps

module spi_nvsram_slave_port_tb_top;
    logic clk = 1'b0;
    logic resetn, wp_n, power_fail, ext_low, pin;
    logic cs_n, sck, si, hold_n, so, so_oe, pin_o, pin_oe, standby, busy, st_p, rc_p;
    logic [7:0] tx [8];
    logic [7:0] rx [8];
    logic [7:0] mdl [int];
    logic [31:0] seed = 32'h23cf2831;
    int mismatches = 0, n_compared = 0, n_store = 0, n_recall = 0, oe_cnt = 0;
    int run = 0, last_run = 0, hrun = 0, last_h = 0;
    bit hold_q = 0;
    // Open drain pin with pull-up
    assign pin = (pin_oe ? pin_o : 1'b1) & ~ext_low;

    nvsp_slave_port dut_u (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_n), .hold_n(hold_n), .power_fail(power_fail), .store_busy_pin_i(pin),
        .so(so), .so_oe(so_oe), .store_busy_pin_o(pin_o), .store_busy_pin_oe(pin_oe),
        .standby(standby), .busy(busy), .nv_store_start(st_p), .nv_recall_start(rc_p));
    nvsp_master mst_u (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so),
        .so_oe(so_oe));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic bit prot(input logic [1:0] bp, input logic [16:0] a);
        return bp == 2'h3 || (bp == 2'h2 && a[16]) || (bp == 2'h1 && a[16:15] == 2'h3);
    endfunction : prot

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // ========
    // Monitors
    always @(negedge clk) begin
        if (busy === 1'b1) run++;
        else if (run > 0) {last_run, run} = {run, 32'h0};
        if (pin_oe === 1'b1 && pin_o === 1'b1) hrun++;
        else if (hrun > 0) {last_h, hrun} = {hrun, 32'h0};
        if (st_p === 1'b1) n_store++;
        if (rc_p === 1'b1) n_recall++;
        if (so_oe === 1'b1) oe_cnt++;
        if (busy === 1'b1) check("busy_pin", {pin_oe, pin_o}, 2'b10);
    end

    // ========
    // Transfers
    task automatic frame(input int n);
        logic m;
        m = 1'(xs());
        mst_u.sel(1'b1, m);
        check("standby_on", standby, 0);
        for (int i = 0; i < n; i++) mst_u.shift(tx[i], hold_q && i == n - 1, rx[i]);
        mst_u.sel(1'b0, m);
        check("so_oe_idle", so_oe, 0);
        check("standby", standby, 1);
    endtask : frame

    task automatic cmd(input logic [7:0] c, input logic [7:0] d, input int n);
        tx[0] = c;
        tx[1] = d;
        frame(n);
    endtask : cmd

    task automatic acc(input logic [7:0] c, input logic [16:0] a, input int nd);
        tx[0] = c;
        tx[1] = {7'h00, a[16]};
        tx[2] = a[15:8];
        tx[3] = a[7:0];
        frame(4 + nd);
    endtask : acc

    task automatic wr_rd(input logic [16:0] a, input int nd, input logic [1:0] bp);
        logic [16:0] x;
        for (int i = 0; i < nd; i++) begin
            x = a + 17'(i);
            tx[4 + i] = 8'(xs());
            if (!prot(bp, x)) mdl[int'(x)] = tx[4 + i];
        end
        acc(8'h02, a, nd);
        acc(8'h03, a, nd);
        for (int i = 0; i < nd; i++) begin
            x = a + 17'(i);
            if (mdl.exists(int'(x))) check("rdata", rx[4 + i], mdl[int'(x)]);
        end
    endtask : wr_rd

    task automatic nv(input int blen, input int hlen);
        repeat (20) @(negedge clk);
        last_h = 0;
        repeat (2000) if (busy !== 1'b0 || pin_oe !== 1'b0) @(negedge clk);
        // Let the monitor close the runs seen at this edge
        @(negedge clk);
        check("busy_len", last_run, blen);
        check("hi_len", last_h, hlen);
        check("pin_rel", pin_oe, 0);
    endtask : nv

    task automatic req(input bit pf);
        @(negedge clk);
        if (pf) power_fail = 1'b1;
        else ext_low = 1'b1;
        repeat (10) @(negedge clk);
        {power_fail, ext_low} = 2'b00;
        repeat (20) @(negedge clk);
    endtask : req

    initial begin
        #900000;
        mismatches++;
        finish_test();
    end

    initial begin
        int k;
        {resetn, wp_n, power_fail, ext_low} = 4'b0100;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        // Recall starts in the last reset cycle; busy also seen one cycle earlier
        nv(201, 0);
        cmd(8'h06, 8'h00, 1);
        wr_rd(17'h1fffe, 4, 2'h0);
        wr_rd(17'h0ffff, 2, 2'h0);
        for (int i = 0; i < 10; i++) begin
            hold_q = (i == 3);
            wr_rd(17'(xs()), 1 + int'(xs() % 4), 2'h0);
        end
        $display("done: burst");
        cmd(8'h04, 8'h00, 1);
        wr_rd(17'h1fffe, 4, 2'h3);
        for (int b = 1; b < 4; b++) begin
            cmd(8'h06, 8'h00, 1);
            cmd(8'h01, {4'h0, 2'(b), 2'h0}, 2);
            cmd(8'h06, 8'h00, 1);
            cmd(8'h05, 8'h00, 2);
            check("status", rx[1], {4'h0, 2'(b), 2'h2});
            wr_rd(17'h1fffe, 4, 2'(b));
            wr_rd(17'h0ffff, 2, 2'(b));
        end
        cmd(8'h01, 8'h80, 2);
        @(negedge clk) wp_n = 1'b0;
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h8c, 2);
        cmd(8'h05, 8'h00, 2);
        // Refused status write still clears the enable latch
        check("wp_status", rx[1], 8'h80);
        @(negedge clk) wp_n = 1'b1;
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h00, 2);
        $display("done: protect");
        k = n_store;
        cmd(8'h30, 8'h00, 1);
        check("sw_store", n_store - k, 1);
        k = oe_cnt;
        acc(8'h03, 17'h00000, 1);
        check("blocked", oe_cnt - k, 0);
        nv(800, 5);
        k = n_recall;
        cmd(8'h31, 8'h00, 1);
        nv(200, 0);
        check("recall", n_recall - k, 1);
        mdl.delete();
        k = n_store;
        req(1'b0);
        check("clean_skip", n_store - k, 0);
        cmd(8'h06, 8'h00, 1);
        wr_rd(17'h00100, 1, 2'h0);
        req(1'b0);
        nv(800, 5);
        check("pin_store", n_store - k, 1);
        cmd(8'h33, 8'h00, 1);
        wr_rd(17'h00200, 1, 2'h0);
        req(1'b1);
        check("auto_off", n_store - k, 1);
        cmd(8'h32, 8'h00, 1);
        req(1'b1);
        nv(800, 5);
        check("auto_on", n_store - k, 2);
        $display("done: store");
        finish_test();
    end
endmodule : spi_nvsram_slave_port_tb_top
